/* File: olsc_inverter_model.sv */
// Inverter bridge model that counts shoot-through cycles
`timescale 1ns/1ps
module olsc_inverter_model (
  input  wire logic       clk_i,   // Clock
  input  wire logic [5:0] pwm_i,   // Gates AH,AL,BH,BL,CH,CL
  output logic      [2:0] legs_o,  // Legs pulled to the supply
  output int              shorts_o // Shoot-through count
);
  initial shorts_o = 0;
  // A leg follows its high switch
  assign legs_o = {pwm_i[5], pwm_i[3], pwm_i[1]};
  // Both switches of a leg short the bus
  always @(posedge clk_i) begin
    if ((pwm_i[5] & pwm_i[4]) | (pwm_i[3] & pwm_i[2]) | (pwm_i[1] & pwm_i[0])) shorts_o <= shorts_o + 1;
  end
endmodule : olsc_inverter_model

/* File: olsc_map.svh */
// Register offsets, field positions, reset values and timing counts for the start-up commutator
`ifndef OLSC_MAP_SVH
`define OLSC_MAP_SVH

// Register byte offsets
`define OLSC_CTRL_OFS       8'h00
`define OLSC_INIT_OFS       8'h04
`define OLSC_TARGET_OFS     8'h08
`define OLSC_DELAY_OFS      8'h0C
`define OLSC_DUTY_OFS       8'h10
`define OLSC_STATUS_OFS     8'h14
`define OLSC_PERIOD_OFS     8'h18
`define OLSC_TICKS_OFS      8'h1C
`define OLSC_IRQ_STAT_OFS   8'h20
`define OLSC_IRQ_MASK_OFS   8'h24

// Control register fields
`define OLSC_CTRL_RUN_BIT   0
`define OLSC_CTRL_START_BIT 1

// Interrupt bit positions
`define OLSC_IRQ_DONE_BIT   0
`define OLSC_IRQ_STEP_BIT   1

// Reset values and the ramp done flag value
`define OLSC_INIT_RST       16'h0400
`define OLSC_TARGET_RST     16'h0100
`define OLSC_DELAY_RST      16'h0004
`define OLSC_DUTY_RST       16'h1000
`define OLSC_DONE_VALUE     16'h7FFF

// Sampling tick period in clock cycles, 20 kHz loop at 200 MHz
`define OLSC_CLK_HZ         200000000
`define OLSC_LOOP_HZ        20000
`define OLSC_TICK_CYCLES    (`OLSC_CLK_HZ / `OLSC_LOOP_HZ)

// PWM carrier period in clock cycles
`define OLSC_PWM_PERIOD     16'h2710

`endif

/* File: olsc_pkg.sv */
// Types shared by the start-up commutator
package olsc_pkg;

  // Six commutation states as one-hot codes
  typedef enum logic [5:0] {
    OLSC_S0 = 6'b00_0001,
    OLSC_S1 = 6'b00_0010,
    OLSC_S2 = 6'b00_0100,
    OLSC_S3 = 6'b00_1000,
    OLSC_S4 = 6'b01_0000,
    OLSC_S5 = 6'b10_0000
  } olsc_state_t;

  typedef logic [15:0] olsc_word_t;

endpackage : olsc_pkg

/* File: olsc_top.sv */
// Open-loop start-up commutator with Wishbone register access
//
// The placing of the registers and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`include "olsc_map.svh"

module olsc_top #(
  parameter int TICK_CYCLES = `OLSC_TICK_CYCLES, // Clock cycles per sampling tick
  parameter int PWM_PERIOD  = `OLSC_PWM_PERIOD   // Clock cycles per PWM carrier period
) (
  input  wire logic              clk_i,  // System clock, 200 MHz
  input  wire logic              rst_i,  // Synchronous reset, active high
  input  wire logic              cyc_i,  // Wishbone cycle
  input  wire logic              stb_i,  // Wishbone strobe
  input  wire logic              we_i,   // Wishbone write enable
  input  wire logic [7:0]        adr_i,  // Wishbone byte address
  input  wire logic [3:0]        sel_i,  // Wishbone byte selects
  input  wire logic [31:0]       dat_i,  // Wishbone write data
  output logic      [31:0]       dat_o,  // Wishbone read data
  output logic                   ack_o,  // Wishbone acknowledge
  output logic                   irq_o,  // Level interrupt
  output olsc_pkg::olsc_word_t   period_o, // Current ramp period
  output logic      [2:0]        pointer_o, // Commutation pointer
  output logic                   impulse_o, // One-clock commutation impulse
  output logic      [5:0]        pwm_o   // Inverter gates: AH,AL,BH,BL,CH,CL
);
  import olsc_pkg::*;

  // Elaboration checks, both dividers are 16 bits wide
  if (TICK_CYCLES < 2 || TICK_CYCLES > 65535) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end
  if (PWM_PERIOD < 2 || PWM_PERIOD > 65535) begin : g_bad_pwm
    $error("PWM_PERIOD out of range");
  end

  // Software registers
  logic        run_r;       // Run enable flag
  logic        start_r;     // Restart pulse request
  olsc_word_t  init_r;      // Initial commutation period
  olsc_word_t  target_r;    // Target commutation period
  olsc_word_t  delay_r;     // Ramp step delay in ticks
  olsc_word_t  duty_r;      // Startup duty, Q15 per-unit
  logic [1:0]  irq_stat_r;  // Sticky events
  logic [1:0]  irq_mask_r;  // Interrupt mask
  logic [31:0] ticks_r;     // Interrupt tick count

  // Block state
  logic [15:0] tick_div_r;  // Sampling tick divider
  logic        tick;        // Sampling tick strobe
  olsc_word_t  period_r;    // Ramp output period
  olsc_word_t  dly_cnt_r;   // Ticks since last ramp step
  olsc_word_t  done_r;      // Ramp done flag
  olsc_word_t  imp_cnt_r;   // Ticks since last impulse
  olsc_state_t state_r;     // Six-state counter
  olsc_state_t state_nxt;   // Next counter state
  logic [15:0] pwm_cnt_r;   // PWM carrier counter
  logic        pwm_on;      // Carrier high phase
  logic [5:0]  pattern;     // Gate pattern for current state
  logic        done_evt;    // Ramp just completed
  logic        acc;         // Bus access this cycle
  logic        rd_stat;     // Read of interrupt status

  assign acc     = cyc_i & stb_i & ~ack_o;
  assign rd_stat = acc & ~we_i & (adr_i == `OLSC_IRQ_STAT_OFS);

  // Wishbone acknowledge, one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= acc;
    end
  end

  // Register writes, low two byte lanes carry the 16-bit fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      run_r      <= 1'b0;
      start_r    <= 1'b0;
      init_r     <= `OLSC_INIT_RST;
      target_r   <= `OLSC_TARGET_RST;
      delay_r    <= `OLSC_DELAY_RST;
      duty_r     <= `OLSC_DUTY_RST;
      irq_mask_r <= 2'h0;
    end else begin
      start_r <= 1'b0;
      if (acc && we_i) begin
        case (adr_i)
          `OLSC_CTRL_OFS: begin
            if (sel_i[0]) begin
              run_r   <= dat_i[`OLSC_CTRL_RUN_BIT];
              start_r <= dat_i[`OLSC_CTRL_START_BIT];
            end
          end
          `OLSC_INIT_OFS: begin
            if (sel_i[0]) init_r[7:0] <= dat_i[7:0];
            if (sel_i[1]) init_r[15:8] <= dat_i[15:8];
          end
          `OLSC_TARGET_OFS: begin
            if (sel_i[0]) target_r[7:0] <= dat_i[7:0];
            if (sel_i[1]) target_r[15:8] <= dat_i[15:8];
          end
          `OLSC_DELAY_OFS: begin
            if (sel_i[0]) delay_r[7:0] <= dat_i[7:0];
            if (sel_i[1]) delay_r[15:8] <= dat_i[15:8];
          end
          `OLSC_DUTY_OFS: begin
            if (sel_i[0]) duty_r[7:0] <= dat_i[7:0];
            if (sel_i[1]) duty_r[15:8] <= dat_i[15:8];
          end
          `OLSC_IRQ_MASK_OFS: begin
            if (sel_i[0]) irq_mask_r <= dat_i[1:0];
          end
          default: begin
            // Read-only or unmapped: write ignored
          end
        endcase
      end
    end
  end

  // Read data mux, unmapped reads as zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h0000_0000;
    end else if (acc && !we_i) begin
      case (adr_i)
        `OLSC_CTRL_OFS:     dat_o <= {31'h0000_0000, run_r};
        `OLSC_INIT_OFS:     dat_o <= {16'h0000, init_r};
        `OLSC_TARGET_OFS:   dat_o <= {16'h0000, target_r};
        `OLSC_DELAY_OFS:    dat_o <= {16'h0000, delay_r};
        `OLSC_DUTY_OFS:     dat_o <= {16'h0000, duty_r};
        `OLSC_STATUS_OFS:   dat_o <= {13'h0000, pointer_o, done_r};
        `OLSC_PERIOD_OFS:   dat_o <= {16'h0000, period_r};
        `OLSC_TICKS_OFS:    dat_o <= ticks_r;
        `OLSC_IRQ_STAT_OFS: dat_o <= {30'h0000_0000, irq_stat_r};
        `OLSC_IRQ_MASK_OFS: dat_o <= {30'h0000_0000, irq_mask_r};
        default:            dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Sampling tick generator, free running
  always_ff @(posedge clk_i) begin
    if (rst_i || tick_div_r == 16'(TICK_CYCLES - 1)) begin
      tick_div_r <= 16'h0000;
    end else begin
      tick_div_r <= tick_div_r + 16'h0001;
    end
  end
  assign tick = (tick_div_r == 16'(TICK_CYCLES - 1));

  // Interrupt tick counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ticks_r <= 32'h0000_0000;
    end else if (run_r && tick) begin
      ticks_r <= ticks_r + 32'h0000_0001;
    end
  end

  // Start-up ramp, speed-up time = (delay + 1) x tick x (init - target)
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_r  <= `OLSC_INIT_RST;
      dly_cnt_r <= 16'h0000;
      done_r    <= 16'h0000;
    end else if (!run_r || start_r) begin
      period_r  <= init_r;
      dly_cnt_r <= 16'h0000;
      done_r    <= 16'h0000;
    end else if (tick) begin
      if (period_r <= target_r) begin
        done_r <= `OLSC_DONE_VALUE;
      end else if (dly_cnt_r >= delay_r) begin
        period_r  <= period_r - 16'h0001;
        dly_cnt_r <= 16'h0000;
      end else begin
        dly_cnt_r <= dly_cnt_r + 16'h0001;
      end
    end
  end
  assign done_evt = tick && run_r && !start_r && (period_r <= target_r) && (done_r == 16'h0000);

  // Impulse generator at ramp period spacing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      imp_cnt_r <= 16'h0000;
      impulse_o <= 1'b0;
    end else if (!run_r) begin
      imp_cnt_r <= 16'h0000;
      impulse_o <= 1'b0;
    end else begin
      impulse_o <= 1'b0;
      if (tick) begin
        if (imp_cnt_r + 16'h0001 >= period_r) begin
          imp_cnt_r <= 16'h0000;
          impulse_o <= 1'b1;
        end else begin
          imp_cnt_r <= imp_cnt_r + 16'h0001;
        end
      end
    end
  end

  // Six-state counter next state
  always_comb begin
    case (state_r)
      OLSC_S0: state_nxt = OLSC_S1;
      OLSC_S1: state_nxt = OLSC_S2;
      OLSC_S2: state_nxt = OLSC_S3;
      OLSC_S3: state_nxt = OLSC_S4;
      OLSC_S4: state_nxt = OLSC_S5;
      OLSC_S5: state_nxt = OLSC_S0;
      default: state_nxt = OLSC_S0;
    endcase
  end

  // Six-state counter update on impulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= OLSC_S0;
    end else if (impulse_o) begin
      state_r <= state_nxt;
    end
  end

  // Pointer value 0..5 from one-hot state
  always_comb begin
    case (state_r)
      OLSC_S0: pointer_o = 3'd0;
      OLSC_S1: pointer_o = 3'd1;
      OLSC_S2: pointer_o = 3'd2;
      OLSC_S3: pointer_o = 3'd3;
      OLSC_S4: pointer_o = 3'd4;
      OLSC_S5: pointer_o = 3'd5;
      default: pointer_o = 3'd0;
    endcase
  end

  // Gate patterns: high side chopped, low side held on
  always_comb begin
    case (state_r)
      OLSC_S0: pattern = 6'b10_0100; // A+ B-
      OLSC_S1: pattern = 6'b10_0001; // A+ C-
      OLSC_S2: pattern = 6'b00_1001; // B+ C-
      OLSC_S3: pattern = 6'b01_1000; // B+ A-
      OLSC_S4: pattern = 6'b01_0010; // C+ A-
      OLSC_S5: pattern = 6'b00_0110; // C+ B-
      default: pattern = 6'b00_0000;
    endcase
  end

  // PWM carrier counter
  always_ff @(posedge clk_i) begin
    if (rst_i || pwm_cnt_r == 16'(PWM_PERIOD - 1)) begin
      pwm_cnt_r <= 16'h0000;
    end else begin
      pwm_cnt_r <= pwm_cnt_r + 16'h0001;
    end
  end
  // Compare against Q15 duty scaled to carrier period
  assign pwm_on = ({16'h0000, pwm_cnt_r} < ((32'(PWM_PERIOD) * {17'h0_0000, duty_r[14:0]}) >> 15));

  // Gate outputs registered, all off when not running
  always_ff @(posedge clk_i) begin
    if (rst_i || !run_r) begin
      pwm_o <= 6'b00_0000;
    end else begin
      pwm_o <= {pattern[5] & pwm_on, pattern[4],
                pattern[3] & pwm_on, pattern[2],
                pattern[1] & pwm_on, pattern[0]};
    end
  end

  // Sticky interrupt status, set wins over read clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat_r <= 2'b00;
    end else begin
      irq_stat_r <= (rd_stat ? 2'b00 : irq_stat_r) | {impulse_o, done_evt};
    end
  end

  // Interrupt output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(irq_stat_r & irq_mask_r);
    end
  end

  assign period_o = period_r;

endmodule : olsc_top

/* File: olsc_top_asserts.sv */
// Port checker for the start-up commutator
`timescale 1ns/1ps
module olsc_top_asserts #(
  parameter int TICK_CYCLES = 8, // Clocks per tick
  parameter int PWM_PERIOD  = 16 // Clocks per carrier
) (
  input wire logic                 clk_i,     // Clock
  input wire logic                 rst_i,     // Reset
  input wire logic                 cyc_i,     // Cycle
  input wire logic                 stb_i,     // Strobe
  input wire logic                 we_i,      // Write
  input wire logic [7:0]           adr_i,     // Address
  input wire logic [3:0]           sel_i,     // Selects
  input wire logic [31:0]          dat_i,     // Write data
  input wire logic [31:0]          dat_o,     // Read data
  input wire logic                 ack_o,     // Ack
  input wire logic                 irq_o,     // Interrupt
  input wire olsc_pkg::olsc_word_t period_o,  // Period
  input wire logic [2:0]           pointer_o, // Pointer
  input wire logic                 impulse_o, // Impulse
  input wire logic [5:0]           pwm_o      // Gates
);
  logic run_r; // Run bit as last written
  // Track the run bit from acked control writes
  always_ff @(posedge clk_i) begin
    if (rst_i) run_r <= 1'b0;
    else if (cyc_i && stb_i && we_i && ack_o && adr_i == 8'h00) run_r <= dat_i[0];
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ptr_range; pointer_o <= 3'h5; endproperty
  a_ptr_range: assert property (p_ptr_range) else $error("pointer out of range");
  property p_ptr_step;
    $changed(pointer_o) |-> pointer_o == (($past(pointer_o) == 3'h5) ? 3'h0 : $past(pointer_o) + 3'h1);
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("pointer skipped a state");
  property p_ptr_cause; $changed(pointer_o) |-> $past(impulse_o) || $past(impulse_o, 2); endproperty
  a_ptr_cause: assert property (p_ptr_cause) else $error("pointer moved without impulse");
  property p_imp_single; impulse_o |=> !impulse_o; endproperty
  a_imp_single: assert property (p_imp_single) else $error("impulse longer than one clock");
  property p_ack_pulse; ack_o |=> !ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ack_resp; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
  // Restart writes reload the period, so the cycle after a control ack is skipped
  property p_step_one;
    run_r && $past(run_r) && !$past(ack_o && we_i && adr_i == 8'h00) && $changed(period_o)
      |-> period_o == $past(period_o) - 16'h0001;
  endproperty
  a_step_one: assert property (p_step_one) else $error("period step not one count");
  property p_gates_off; !run_r && !$past(run_r) && !$past(run_r, 2) |-> pwm_o == 6'h00; endproperty
  a_gates_off: assert property (p_gates_off) else $error("gates on while stopped");
  property p_no_shoot; !((pwm_o[5] && pwm_o[4]) || (pwm_o[3] && pwm_o[2]) || (pwm_o[1] && pwm_o[0])); endproperty
  a_no_shoot: assert property (p_no_shoot) else $error("both switches of a leg on");
  property p_low_one; run_r && $past(run_r, 3) |-> $onehot({pwm_o[4], pwm_o[2], pwm_o[0]}); endproperty
  a_low_one: assert property (p_low_one) else $error("low side not one-hot");
  c_wrap: cover property (impulse_o && pointer_o == 3'h5);
  c_irq: cover property (irq_o);
  c_write: cover property (ack_o && we_i);
endmodule : olsc_top_asserts

/* File: olsc_top_tb_top.sv */
// Self-checking bench for the start-up commutator
`timescale 1ns/1ps
module olsc_top_tb_top;
  import olsc_pkg::*;
  localparam int TK = 8;     // Clocks per tick
  localparam int LIM = 4000; // Bound on waits
  logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, irq_o, impulse_o;
  logic [7:0] adr_i = 0;
  logic [3:0] sel_i = 0;
  logic [31:0] dat_i = 0, dat_o, q, seed = 32'h0000_003D;
  olsc_word_t period_o, init_v, tgt_v, dly_v, duty_v, pv;
  logic [2:0] pointer_o, legs;
  logic [5:0] pwm_o, seen, pat [6];
  int n_errors = 0, cmp_count = 0, n, k, hs, t1, shorts;
  always #2.5 clk_i = ~clk_i;
  olsc_top #(.TICK_CYCLES(TK), .PWM_PERIOD(16)) u_dut (.clk_i(clk_i), .rst_i(rst_i),
    .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o), .period_o(period_o), .pointer_o(pointer_o),
    .impulse_o(impulse_o), .pwm_o(pwm_o));
  olsc_inverter_model u_inv (.clk_i(clk_i), .pwm_i(pwm_o), .legs_o(legs), .shorts_o(shorts));
  // Xorshift source
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  // High-side on cycles in two carriers
  function automatic int hs_exp(input olsc_word_t d);
    return 2 * (int'(d) >> 11);
  endfunction : hs_exp
  task automatic report_and_stop();
    $display("Counts: %0d compares, %0d mismatches", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One classic Wishbone cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_i);
    cyc_i <= 1;
    stb_i <= 1;
    we_i <= w;
    adr_i <= a;
    sel_i <= 4'hF;
    dat_i <= d;
    for (i = 0; i <= 50 && ack_o !== 1'b1; i++) @(posedge clk_i);
    if (i > 50) begin
      n_errors++;
      report_and_stop();
    end
    q = dat_o;
    cyc_i <= 0;
    stb_i <= 0;
  endtask : wb
  // Wait for an impulse or a period change
  task automatic wfor(input bit imp);
    pv = period_o;
    @(posedge clk_i);
    for (n = 1; n < LIM && (imp ? impulse_o !== 1'b1 : period_o === pv); n++) @(posedge clk_i);
    if (n == LIM) begin
      n_errors++;
      report_and_stop();
    end
  endtask : wfor
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    wb(0, 8'h04, 0);
    chk(q, 32'h0000_0400);
    wb(0, 8'h0C, 0);
    chk(q, 32'h0000_0004);
    wb(0, 8'h28, 0);
    chk(q, 0);
    chk(32'(pwm_o), 0);
    $display("test reset done");
    tgt_v = 16'h0008 + 16'(rnd() % 8);
    init_v = tgt_v + 16'h0003 + 16'(rnd() % 4);
    dly_v = 16'(rnd() % 3);
    duty_v = 16'((rnd() % 15 + 1) << 11);
    wb(1, 8'h04, 32'(init_v));
    wb(1, 8'h08, 32'(tgt_v));
    wb(1, 8'h0C, 32'(dly_v));
    wb(1, 8'h10, 32'(duty_v));
    wb(1, 8'h18, 32'h0000_FFFF);
    wb(1, 8'h24, 1);
    wb(0, 8'h18, 0);
    chk(q, 32'(init_v));
    wb(1, 8'h00, 1);
    wfor(0);
    k = 1;
    while (period_o !== tgt_v && k < 40) begin
      wfor(0);
      k++;
      chk(n, (int'(dly_v) + 1) * TK);
    end
    chk(k, 32'(init_v - tgt_v));
    repeat (4 * TK) @(posedge clk_i);
    wb(0, 8'h14, 0);
    chk(32'(q[15:0]), 32'h0000_7FFF);
    chk(32'(irq_o), 1);
    wb(0, 8'h20, 0);
    chk(32'(q[0]), 1);
    repeat (3) @(posedge clk_i);
    chk(32'(irq_o), 0);
    repeat (3 * (int'(dly_v) + 1) * TK) @(posedge clk_i);
    chk(32'(period_o), 32'(tgt_v));
    $display("test ramp done");
    wfor(1);
    wfor(1);
    chk(n, int'(tgt_v) * TK);
    seen = 0;
    for (k = 0; k < 6; k++) begin
      wfor(1);
      repeat (3) @(posedge clk_i);
      hs = 0;
      t1 = pointer_o;
      pat[t1] = 0;
      repeat (32) begin
        @(posedge clk_i);
        hs += (|legs);
        pat[t1] |= pwm_o;
      end
      chk(hs, hs_exp(duty_v));
      seen[t1] = 1;
    end
    chk(32'(seen), 32'h3F);
    for (k = 0; k < 6; k++)
      for (n = k + 1; n < 6; n++) chk(32'(pat[k] == pat[n]), 0);
    chk(shorts, 0);
    $display("test commutation done");
    wb(1, 8'h00, 3);
    @(posedge clk_i);
    chk(32'(period_o), 32'(init_v));
    wb(0, 8'h14, 0);
    chk(32'(q[15:0]), 0);
    wb(0, 8'h00, 0);
    chk(q, 1);
    $display("test restart done");
    wb(0, 8'h1C, 0);
    t1 = q;
    repeat (10 * TK) @(posedge clk_i);
    wb(0, 8'h1C, 0);
    chk(32'(q - t1 >= 10 && q - t1 <= 11), 1);
    wb(1, 8'h24, 2);
    wfor(1);
    repeat (3) @(posedge clk_i);
    chk(32'(irq_o), 1);
    wb(0, 8'h20, 0);
    chk(32'(q[1]), 1);
    @(posedge clk_i);
    chk(32'(irq_o), 0);
    wb(1, 8'h24, 0);
    repeat (2) @(posedge clk_i);
    chk(32'(irq_o), 0);
    $display("test ticks and irq done");
    report_and_stop();
  end
endmodule : olsc_top_tb_top
bind olsc_top olsc_top_asserts #(.TICK_CYCLES(TICK_CYCLES), .PWM_PERIOD(PWM_PERIOD)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
  .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .irq_o(irq_o),
  .period_o(period_o), .pointer_o(pointer_o), .impulse_o(impulse_o), .pwm_o(pwm_o));
